// ---- tcs_pkg.sv ----
package tcs_pkg;
    // Task set and grouping
    localparam int NTASK = 8;
    localparam int NGRP = 4;
    localparam logic [2:0] TSK_RX1 = 3'h0;
    localparam logic [2:0] TSK_RX2 = 3'h1;
    localparam logic [2:0] TSK_OBS1 = 3'h2;
    localparam logic [2:0] TSK_OBS2 = 3'h3;
    localparam logic [2:0] TSK_TX1_LEAK = 3'h4;
    localparam logic [2:0] TSK_TX2_LEAK = 3'h5;
    localparam logic [2:0] TSK_TX1_QC = 3'h6;
    localparam logic [2:0] TSK_TX2_QC = 3'h7;
    localparam logic [1:0] GRP_RX = 2'h0;
    localparam logic [1:0] GRP_OBS = 2'h1;
    localparam logic [1:0] GRP_TX_LEAK = 2'h2;
    localparam logic [1:0] GRP_TX_QC = 2'h3;
    // Slot 0 is priority 1
    localparam logic [7:0] PRIO_SEQ = {GRP_RX, GRP_OBS, GRP_TX_QC, GRP_TX_LEAK};
    // Controller state codes
    localparam logic [2:0] CODE_PWRUP = 3'h0;
    localparam logic [2:0] CODE_READY = 3'h1;
    localparam logic [2:0] CODE_OFF = 3'h2;
    localparam logic [2:0] CODE_ON = 3'h3;
    localparam logic [2:0] CODE_FAULT = 3'h4;
    // Outstanding flag layout
    localparam int FLAG_PEND_OFS = 0;
    localparam int FLAG_ERR_OFS = 1;
    localparam int FLAG_STRIDE = 2;
    // Timing
    localparam int CLK_MHZ = 40;
    localparam int BATCH_US = 800;
    localparam int TASK_PERIOD_US = 10000;
    localparam int BATCH_CNT_W = 16;
    localparam int PERIOD_W = 24;
    localparam int NBAT_W = 5;
    localparam logic [NBAT_W-1:0] BATCHES_NEEDED = 5'h10;

    typedef enum logic [2:0] {ST_PWRUP, ST_READY, ST_OFF, ST_ON, ST_FAULT} tcs_ctl_t;
    typedef enum logic [1:0] {SCH_IDLE, SCH_BATCH, SCH_CORR} tcs_sch_t;

    typedef struct packed {
        logic [1:0] rx_en;
        logic [1:0] tx_en;
        logic [1:0] observation_receiver_en;
        logic observation_receiver_lent;
    } tcs_paths_t;

    typedef struct packed {
        logic done;
        logic ok;
    } tcs_corr_t;

    typedef struct packed {
        logic [PERIOD_W-1:0] tmr;
        logic [NBAT_W-1:0] nbat;
        logic pend;
        logic err;
    } tcs_task_st_t;

    typedef struct packed {
        tcs_ctl_t ctl;
        tcs_sch_t sch;
        logic [NTASK-1:0] mask;
        logic [2:0] task_id;
        logic [BATCH_CNT_W-1:0] bcnt;
        logic [NGRP-1:0] favor;
        logic [31:0] flags;
        logic [2:0] code;
        logic act;
        logic corr_req;
        logic refused;
        logic discarded;
    } tcs_top_st_t;
endpackage : tcs_pkg

// ---- tcs_pair_pick.sv ----
`timescale 1ns/1ps
module tcs_pair_pick (
    // Two equal-priority candidates
    input wire logic [1:0] cand,
    input wire logic favor_b,
    // Choice
    output logic valid,
    output logic sel
);
    always_comb begin
        valid = |cand;
        sel = cand[1] & (~cand[0] | favor_b); // RQ11
    end
endmodule : tcs_pair_pick

// ---- tcs_cal_task.sv ----
`timescale 1ns/1ps
module tcs_cal_task #(
    parameter int PERIOD_CYCLES = tcs_pkg::TASK_PERIOD_US * tcs_pkg::CLK_MHZ
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic enable,
    input wire logic batch_done,
    input wire logic corr_done,
    input wire logic corr_ok,
    // Status
    output logic pending,
    output logic error,
    output logic enough
);
    import tcs_pkg::*;

    localparam logic [PERIOD_W-1:0] TMR_LAST = PERIOD_W'(PERIOD_CYCLES - 1);

    tcs_task_st_t st_ff;
    tcs_task_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (!enable) begin
            // Deselected or radio off: timer and partial data dropped
            nxt_st.tmr = '0;
            nxt_st.nbat = '0;
            nxt_st.pend = 1'b0;
        end else begin
            if (corr_done) begin
                nxt_st.nbat = '0;
                nxt_st.pend = 1'b0; // RQ15
                nxt_st.err = ~corr_ok; // RQ21
            end else if (batch_done && st_ff.nbat != BATCHES_NEEDED) begin
                nxt_st.nbat = st_ff.nbat + 1'b1;
            end
            // Period runs from the last correction
            if (!st_ff.pend) begin
                if (st_ff.tmr == TMR_LAST) begin
                    nxt_st.tmr = '0;
                    nxt_st.pend = 1'b1; // RQ8
                end else begin
                    nxt_st.tmr = st_ff.tmr + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_comb begin
        pending = st_ff.pend;
        error = st_ff.err;
        enough = st_ff.nbat == BATCHES_NEEDED;
    end

    pend_timer_a: assert property (@(posedge clk) disable iff (rst) // RQ8
        enable && !st_ff.pend && st_ff.tmr == TMR_LAST ##1 enable |-> st_ff.pend)
        else $error("pending flag not raised at timer expiry");
endmodule : tcs_cal_task

// ---- tcs_scheduler.sv ----
// What this block does
// RQ1: Receive tasks run only with chain enabled.
// RQ2: Transmit tasks also need lent observation path.
// RQ3: After init, controller settles in radio off.
// RQ4: Radio off: scheduler idle, chains powered down.
// RQ5: Radio on: scheduler active, chains available.
// RQ6: State code 0..3; above 3 means error.
// RQ7: Radio on starts one task per mask bit.
// RQ8: Task timer expiry sets its pending flag.
// RQ9: Flag pairs: pending even, error odd bits.
// RQ10: Lowest priority number wins among runnable.
// RQ11: Equal priority: earliest completed task first.
// RQ12: Skip tasks lacking paths; take next runnable.
// RQ13: Selected task observes one 800 us batch.
// RQ14: Re-arbitrate after every batch.
// RQ15: Enough batches: correct, then clear pending.
// RQ16: Disrupted batch is discarded without effect.
// RQ17: Host lends path in 800 us multiples.
// RQ18: Host lends path 400 ms every 2 s.
// RQ19: Device never seizes the observation path.
// RQ20: Mask changes refused while radio on.
// RQ21: Upper flag bits zero; failed correction sets error.
`timescale 1ns/1ps
module tcs_scheduler #(
    parameter int BATCH_CYCLES = tcs_pkg::BATCH_US * tcs_pkg::CLK_MHZ,
    parameter int TASK_PERIOD_CYCLES = tcs_pkg::TASK_PERIOD_US * tcs_pkg::CLK_MHZ
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Controller sequencing
    input wire logic boot_done,
    input wire logic init_done,
    input wire logic cfg_fault,
    input wire logic radio_on_req,
    input wire logic radio_off_req,
    // Tracking selection
    input wire logic mask_wr,
    input wire logic [tcs_pkg::NTASK-1:0] mask_wdata,
    // Path availability from host
    input tcs_pkg::tcs_paths_t paths,
    // Correction engine
    output logic corr_req,
    output logic [2:0] corr_task,
    input tcs_pkg::tcs_corr_t corr_rsp,
    // Status
    output logic [2:0] controller_state_code,
    output logic [tcs_pkg::NTASK-1:0] tracking_select_mask,
    output logic [31:0] outstanding_task_flags,
    output logic scheduler_active,
    output logic chains_powered,
    output logic batch_active,
    output logic [2:0] batch_task,
    output logic mask_write_refused,
    output logic batch_discarded
);
    import tcs_pkg::*;

    localparam logic [BATCH_CNT_W-1:0] BATCH_LAST = BATCH_CNT_W'(BATCH_CYCLES - 1);

    tcs_top_st_t st_ff;
    tcs_top_st_t nxt_st;

    logic on_st;
    logic [NTASK-1:0] path_ok;
    logic [NTASK-1:0] pend;
    logic [NTASK-1:0] err;
    logic [NTASK-1:0] enough;
    logic [NTASK-1:0] cand;
    logic [NTASK-1:0] t_batch_done;
    logic [NTASK-1:0] t_corr_done;
    logic [NGRP-1:0] gv;
    logic [NGRP-1:0] gsel;
    logic bdone;
    logic pick_ok;
    logic [2:0] pick_id;
    logic corr_ok_any;
    logic [2:0] corr_id;

    assign on_st = st_ff.ctl == ST_ON;

    // Paths each task needs; transmit tasks take the observation path only when lent, observation tasks when it is enabled
    always_comb begin
        path_ok[TSK_RX1] = paths.rx_en[0]; // RQ1
        path_ok[TSK_RX2] = paths.rx_en[1]; // RQ1
        path_ok[TSK_OBS1] = paths.observation_receiver_en[0];
        path_ok[TSK_OBS2] = paths.observation_receiver_en[1];
        path_ok[TSK_TX1_LEAK] = paths.tx_en[0] & paths.observation_receiver_lent; // RQ2
        path_ok[TSK_TX2_LEAK] = paths.tx_en[1] & paths.observation_receiver_lent; // RQ2
        path_ok[TSK_TX1_QC] = paths.tx_en[0] & paths.observation_receiver_lent; // RQ19
        path_ok[TSK_TX2_QC] = paths.tx_en[1] & paths.observation_receiver_lent; // RQ19
    end

    // Tasks with full data go to correction, not to another batch
    assign cand = pend & path_ok & ~enough; // RQ12

    assign bdone = st_ff.sch == SCH_BATCH && st_ff.bcnt == BATCH_LAST && on_st
        && path_ok[st_ff.task_id] && pend[st_ff.task_id]; // RQ13

    genvar gi;
    generate
        for (gi = 0; gi < NTASK; gi++) begin : g_task
            assign t_batch_done[gi] = bdone && st_ff.task_id == 3'(gi);
            assign t_corr_done[gi] = corr_rsp.done && st_ff.sch == SCH_CORR
                && st_ff.task_id == 3'(gi) && on_st;
            tcs_cal_task #(
                .PERIOD_CYCLES(TASK_PERIOD_CYCLES)
            ) u_task (
                .clk(clk),
                .rst(rst),
                .enable(st_ff.mask[gi] & on_st), // RQ7
                .batch_done(t_batch_done[gi]),
                .corr_done(t_corr_done[gi]),
                .corr_ok(corr_rsp.ok),
                .pending(pend[gi]),
                .error(err[gi]),
                .enough(enough[gi])
            );
        end
        for (gi = 0; gi < NGRP; gi++) begin : g_grp
            tcs_pair_pick u_pick (
                .cand(cand[FLAG_STRIDE*gi +: FLAG_STRIDE]),
                .favor_b(st_ff.favor[gi]),
                .valid(gv[gi]),
                .sel(gsel[gi])
            );
        end
    endgenerate

    // Priority walk, slot 0 first
    always_comb begin
        logic [1:0] g;
        g = '0;
        pick_ok = 1'b0;
        pick_id = '0;
        for (int p = 0; p < NGRP; p++) begin
            g = PRIO_SEQ[2*p +: 2];
            if (!pick_ok && gv[g]) begin
                pick_ok = 1'b1; // RQ10
                pick_id = {g, gsel[g]};
            end
        end
    end

    // Task ready for its correction
    always_comb begin
        corr_ok_any = 1'b0;
        corr_id = '0;
        for (int i = 0; i < NTASK; i++) begin
            if (!corr_ok_any && pend[i] && enough[i]) begin
                corr_ok_any = 1'b1;
                corr_id = 3'(i);
            end
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.corr_req = 1'b0;
        nxt_st.refused = 1'b0;
        nxt_st.discarded = 1'b0;

        // Controller states
        unique case (st_ff.ctl)
            ST_PWRUP: begin
                if (boot_done) begin
                    nxt_st.ctl = ST_READY;
                end
            end
            ST_READY: begin
                if (init_done) begin
                    nxt_st.ctl = ST_OFF; // RQ3
                end
            end
            ST_OFF: begin
                if (radio_on_req) begin
                    nxt_st.ctl = ST_ON; // RQ5
                end
            end
            ST_ON: begin
                if (radio_off_req) begin
                    nxt_st.ctl = ST_OFF; // RQ4
                end
            end
            ST_FAULT: begin
                nxt_st.ctl = ST_FAULT;
            end
            default: begin
                nxt_st.ctl = ST_FAULT;
            end
        endcase
        // Fault is only left through reset
        if (cfg_fault) begin
            nxt_st.ctl = ST_FAULT;
        end

        // Mask only changes outside traffic
        if (mask_wr) begin
            if (st_ff.ctl == ST_ON || st_ff.ctl == ST_FAULT) begin
                nxt_st.refused = 1'b1; // RQ20
            end else begin
                nxt_st.mask = mask_wdata;
            end
        end

        // Scheduler
        unique case (st_ff.sch)
            SCH_IDLE: begin
                // Nothing starts in a cycle that leaves radio on
                if (nxt_st.ctl == ST_ON && corr_ok_any) begin
                    nxt_st.sch = SCH_CORR; // RQ15
                    nxt_st.task_id = corr_id;
                    nxt_st.corr_req = 1'b1;
                end else if (nxt_st.ctl == ST_ON && pick_ok) begin
                    nxt_st.sch = SCH_BATCH; // RQ14
                    nxt_st.task_id = pick_id;
                    nxt_st.bcnt = '0;
                end
            end
            SCH_BATCH: begin
                if (!on_st || !path_ok[st_ff.task_id] || !pend[st_ff.task_id]) begin
                    // Partial observation dropped; the task just waits
                    nxt_st.sch = SCH_IDLE; // RQ16
                    nxt_st.discarded = 1'b1;
                end else if (st_ff.bcnt == BATCH_LAST) begin
                    nxt_st.sch = SCH_IDLE; // RQ14
                end else begin
                    nxt_st.bcnt = st_ff.bcnt + 1'b1;
                end
            end
            SCH_CORR: begin
                if (!on_st) begin
                    nxt_st.sch = SCH_IDLE;
                end else if (corr_rsp.done) begin
                    nxt_st.sch = SCH_IDLE;
                    // Sibling now completed less recently, so it goes first
                    nxt_st.favor[st_ff.task_id[2:1]] = ~st_ff.task_id[0]; // RQ11
                end
            end
            default: begin
                nxt_st.sch = SCH_IDLE;
            end
        endcase
        if (nxt_st.ctl != ST_ON && st_ff.sch == SCH_BATCH) begin
            nxt_st.sch = SCH_IDLE;
            nxt_st.discarded = 1'b1; // RQ16
        end

        // Readable flags
        nxt_st.flags = '0; // RQ21
        for (int i = 0; i < NTASK; i++) begin
            nxt_st.flags[FLAG_STRIDE*i + FLAG_PEND_OFS] = pend[i]; // RQ9
            nxt_st.flags[FLAG_STRIDE*i + FLAG_ERR_OFS] = err[i]; // RQ9
        end

        unique case (nxt_st.ctl)
            ST_PWRUP: nxt_st.code = CODE_PWRUP; // RQ6
            ST_READY: nxt_st.code = CODE_READY;
            ST_OFF: nxt_st.code = CODE_OFF;
            ST_ON: nxt_st.code = CODE_ON;
            default: nxt_st.code = CODE_FAULT; // RQ6
        endcase
        nxt_st.act = nxt_st.ctl == ST_ON; // RQ5
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_comb begin
        controller_state_code = st_ff.code;
        tracking_select_mask = st_ff.mask;
        outstanding_task_flags = st_ff.flags;
        scheduler_active = st_ff.act; // RQ4
        chains_powered = st_ff.act; // RQ4
        batch_active = st_ff.sch == SCH_BATCH;
        batch_task = st_ff.task_id;
        corr_req = st_ff.corr_req;
        corr_task = st_ff.task_id;
        mask_write_refused = st_ff.refused;
        batch_discarded = st_ff.discarded;
    end

    // Independent batch length counter
    logic [BATCH_CNT_W-1:0] chk_cnt_ff;
    always_ff @(posedge clk) begin
        if (rst || st_ff.sch != SCH_BATCH) begin
            chk_cnt_ff <= '0;
        end else begin
            chk_cnt_ff <= chk_cnt_ff + 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    off_entry_a: assert property ( // RQ4
        on_st && radio_off_req && !cfg_fault |=> controller_state_code == CODE_OFF
            && !scheduler_active && !chains_powered && !batch_active)
        else $error("radio off did not stop the scheduler");

    on_entry_a: assert property ( // RQ5
        st_ff.ctl == ST_OFF && radio_on_req && !cfg_fault |=> controller_state_code == CODE_ON
            && scheduler_active && chains_powered)
        else $error("radio on did not start the scheduler");

    init_off_a: assert property ( // RQ3
        st_ff.ctl == ST_READY && init_done && !cfg_fault |=> controller_state_code == CODE_OFF)
        else $error("init completion did not reach radio off");

    mask_refuse_a: assert property ( // RQ20
        mask_wr && on_st |=> mask_write_refused && $stable(tracking_select_mask))
        else $error("mask changed during radio on");

    mask_take_a: assert property ( // RQ7
        mask_wr && st_ff.ctl == ST_OFF |=> tracking_select_mask == $past(mask_wdata)
            && !mask_write_refused)
        else $error("mask write in radio off lost");

    batch_len_a: assert property ( // RQ13
        bdone |-> chk_cnt_ff == BATCH_LAST)
        else $error("batch length wrong");

    tx_lent_a: assert property ( // RQ2
        batch_active && batch_task[2] && !paths.observation_receiver_lent |=> !batch_active
            && batch_discarded)
        else $error("transmit batch kept without lent path");

    rx_start_a: assert property ( // RQ1
        st_ff.sch == SCH_IDLE ##1 batch_active && batch_task == TSK_RX1
            |-> $past(paths.rx_en[0]))
        else $error("receive batch started on disabled chain");

    prio_a: assert property ( // RQ10
        st_ff.sch == SCH_IDLE && on_st && !radio_off_req && !cfg_fault && !corr_ok_any
            && |cand[5:4] |=> batch_active && batch_task[2:1] == GRP_TX_LEAK)
        else $error("leakage task not preferred");

    pend_clear_a: assert property ( // RQ15
        corr_req ##[1:1000] t_corr_done[st_ff.task_id] |=> !pend[$past(st_ff.task_id)])
        else $error("pending not cleared after correction");

    upper_zero_a: assert property ( // RQ21
        outstanding_task_flags[31:16] == 16'h0000 && $past(outstanding_task_flags[0]) == $past(pend[0], 2))
        else $error("flag word layout wrong");

    tie_break_a: assert property ( // RQ11
        st_ff.sch == SCH_IDLE && on_st && !radio_off_req && !cfg_fault && !corr_ok_any
            && cand == 8'h03 |=> batch_active && batch_task[0] == $past(st_ff.favor[0]))
        else $error("equal priority tie broken wrongly");

    tx_needs_lent_a: assert property ( // RQ19
        batch_active && batch_task[2] |-> $past(paths.observation_receiver_lent))
        else $error("transmit batch ran on a path not lent");
endmodule : tcs_scheduler

// ---- tcs_bbp_model.sv ----
`timescale 1ns/1ps
module tcs_bbp_model #(
    parameter int SLOT_CYCLES = 40
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Commands from the bench
    input wire logic lend_on,
    input wire logic reclaim,
    input wire logic eng_ok,
    // Device side
    output logic observation_receiver_lent,
    input wire logic corr_req,
    output tcs_pkg::tcs_corr_t corr_rsp
);
    import tcs_pkg::*;
    int slot_cnt;
    int eng_cnt;
    logic slow;

    always_ff @(posedge clk) begin
        if (rst) begin
            observation_receiver_lent <= 1'b0;
            slot_cnt <= 0;
            eng_cnt <= 0;
            slow <= 1'b0;
            corr_rsp <= '0;
        end else begin
            // Lent in whole multi-batch slots; only a reclaim cuts one short
            if (reclaim) begin
                observation_receiver_lent <= 1'b0;
                slot_cnt <= 0;
            end else if (slot_cnt == 0) begin
                observation_receiver_lent <= lend_on;
                slot_cnt <= lend_on ? 4 * SLOT_CYCLES : 0;
            end else begin
                slot_cnt <= slot_cnt - 1;
            end
            // Engine alternates prompt and slow answers
            if (corr_req) begin
                eng_cnt <= slow ? 6 : 1;
                slow <= ~slow;
            end else if (eng_cnt != 0) begin
                eng_cnt <= eng_cnt - 1;
            end
            corr_rsp.done <= (eng_cnt == 1);
            // Ok is junk outside the done pulse
            corr_rsp.ok <= (eng_cnt == 1) ? eng_ok : ~eng_ok;
        end
    end
endmodule : tcs_bbp_model

// ---- tb_tracking_calibration_scheduler.sv ----
`timescale 1ns/1ps
module tb_tracking_calibration_scheduler;
    import tcs_pkg::*;
    localparam int BC = 40;
    logic clk = 1'b0, rst = 1'b1;
    logic boot_done = 1'b0, init_done = 1'b0, cfg_fault = 1'b0;
    logic radio_on_req = 1'b0, radio_off_req = 1'b0, mask_wr = 1'b0;
    logic [7:0] mask_wdata = 8'h00;
    logic [1:0] rx_en = 2'b00, tx_en = 2'b00;
    logic lend_on = 1'b0, reclaim = 1'b0, eng_ok = 1'b1;
    logic observation_receiver_lent, corr_req, scheduler_active, chains_powered, batch_active;
    logic mask_write_refused, batch_discarded, bact_q = 1'b0;
    logic [2:0] corr_task, controller_state_code, batch_task, e3;
    logic [7:0] tracking_select_mask, rnd;
    logic [31:0] outstanding_task_flags;
    tcs_paths_t paths_s;
    tcs_corr_t corr_rsp;
    logic [2:0] bq[$], cq[$];
    int mismatches = 0, checks = 0, cyc = 0, seed = 32'hba0a, n;

    assign paths_s = {rx_en, tx_en, 2'b00, observation_receiver_lent};

    tcs_scheduler #(.BATCH_CYCLES(BC), .TASK_PERIOD_CYCLES(50)) u_dut (
        .clk(clk), .rst(rst), .boot_done(boot_done), .init_done(init_done),
        .cfg_fault(cfg_fault), .radio_on_req(radio_on_req), .radio_off_req(radio_off_req),
        .mask_wr(mask_wr), .mask_wdata(mask_wdata), .paths(paths_s), .corr_req(corr_req),
        .corr_task(corr_task), .corr_rsp(corr_rsp),
        .controller_state_code(controller_state_code),
        .tracking_select_mask(tracking_select_mask),
        .outstanding_task_flags(outstanding_task_flags), .scheduler_active(scheduler_active),
        .chains_powered(chains_powered), .batch_active(batch_active), .batch_task(batch_task),
        .mask_write_refused(mask_write_refused), .batch_discarded(batch_discarded)
    );

    tcs_bbp_model #(.SLOT_CYCLES(BC)) u_bbp (
        .clk(clk), .rst(rst), .lend_on(lend_on), .reclaim(reclaim), .eng_ok(eng_ok),
        .observation_receiver_lent(observation_receiver_lent), .corr_req(corr_req),
        .corr_rsp(corr_rsp)
    );

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic final_report;
        if (mismatches == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    // One-cycle request, then let its answer land
    task automatic pulse(ref logic sig);
        sig = 1'b1;
        @(negedge clk);
        sig = 1'b0;
        @(negedge clk);
    endtask : pulse

    task automatic next_batch;
        for (n = 0; n < 2000 && batch_active; n++) @(negedge clk);
        for (n = 0; n < 2000 && !batch_active; n++) @(negedge clk);
    endtask : next_batch

    task automatic run_corr;
        for (n = 0; n < 3000 && !corr_req; n++) @(negedge clk);
        for (n = 0; n < 20 && !corr_rsp.done; n++) @(negedge clk);
        repeat (3) @(negedge clk);
    endtask : run_corr

    // Outcome monitor: oldest note against each batch or correction start
    always @(negedge clk) begin
        if (batch_active && !bact_q && bq.size() > 0) begin
            e3 = bq.pop_front();
            check("batch_task", {29'h0, e3}, {29'h0, batch_task});
        end
        if (corr_req && cq.size() > 0) begin
            e3 = cq.pop_front();
            check("corr_task", {29'h0, e3}, {29'h0, corr_task});
        end
        bact_q <= batch_active;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check("code", 32'h0000_0000, {29'h0, controller_state_code});
        pulse(boot_done);
        check("code", 32'h0000_0001, {29'h0, controller_state_code});
        pulse(init_done);
        check("code", 32'h0000_0002, {29'h0, controller_state_code});
        check("active", 32'h0000_0000, {30'h0, scheduler_active, chains_powered});
        rnd = 8'($random(seed));
        mask_wdata = rnd;
        pulse(mask_wr);
        check("mask", {24'h0, rnd}, {24'h0, tracking_select_mask});
        // Rx1, Rx2 and Tx1 leakage; chains up, path not lent yet
        mask_wdata = 8'h13;
        pulse(mask_wr);
        rx_en = 2'b11;
        tx_en = 2'b11;
        bq.push_back(TSK_RX1);
        pulse(radio_on_req);
        check("code", 32'h0000_0003, {29'h0, controller_state_code});
        check("active", 32'h0000_0003, {30'h0, scheduler_active, chains_powered});
        mask_wdata = 8'($random(seed));
        mask_wr = 1'b1;
        @(negedge clk);
        mask_wr = 1'b0;
        check("refused", 32'h0000_0001, {31'h0, mask_write_refused});
        check("mask", 32'h0000_0013, {24'h0, tracking_select_mask});
        next_batch();
        check("pending", 32'h0000_0105, outstanding_task_flags & 32'h0000_0105);
        lend_on = 1'b1;
        bq.push_back(TSK_TX1_LEAK);
        next_batch();
        repeat (10) @(negedge clk);
        lend_on = 1'b0;
        reclaim = 1'b1;
        @(negedge clk);
        reclaim = 1'b0;
        for (n = 0; n < 3 && !batch_discarded; n++) @(negedge clk);
        check("discarded", 32'h0000_0001, {31'h0, batch_discarded});
        bq.push_back(TSK_RX1);
        next_batch();
        lend_on = 1'b1;
        cq.push_back(TSK_TX1_LEAK);
        run_corr();
        check("tx_lol_flags", 32'h0000_0000, outstanding_task_flags & 32'h0000_0300);
        lend_on = 1'b0;
        reclaim = 1'b1;
        eng_ok = 1'b0;
        @(negedge clk);
        reclaim = 1'b0;
        cq.push_back(TSK_RX1);
        run_corr();
        check("rx1_flags", 32'h0000_0002, outstanding_task_flags & 32'h0000_0003);
        check("upper", 32'h0000_0000, outstanding_task_flags & 32'hffff_0000);
        // Rx2 wins twice: Rx1 first waits out its period, then loses the tie to Rx2 after its correction
        bq.push_back(TSK_RX2);
        bq.push_back(TSK_RX2);
        next_batch();
        next_batch();
        pulse(radio_off_req);
        check("code", 32'h0000_0002, {29'h0, controller_state_code});
        check("active", 32'h0000_0000, {30'h0, scheduler_active, chains_powered});
        check("batch", 32'h0000_0000, {31'h0, batch_active});
        pulse(cfg_fault);
        check("code", 32'h0000_0004, {29'h0, controller_state_code});
        mask_wr = 1'b1;
        @(negedge clk);
        mask_wr = 1'b0;
        check("refused", 32'h0000_0001, {31'h0, mask_write_refused});
        final_report();
    end
endmodule : tb_tracking_calibration_scheduler
